/* File: rtl/dlrc_pkg.sv */
/*
 * package for the display link receiver control block: register offsets,
 * field positions, reset values, codes and symbol constants.
 * assumes a 32-bit apb slave and a 125 mhz system clock.
 */
package dlrc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] CTL_OFF       = 12'h000;
	localparam logic [11:0] STAT_OFF      = 12'h004;
	localparam logic [31:0] CTL_RESET     = 32'h0000_0040;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int RX_ON_BIT      = 31;
	localparam int LANE_HI        = 21;
	localparam int LANE_LO        = 19;
	localparam int DEPTH_HI       = 18;
	localparam int DEPTH_LO       = 16;
	localparam int FLIP_BIT       = 15;
	localparam int STRAP_BIT      = 14;
	localparam int PLL_BIT        = 13;
	localparam int SYNC_BIT       = 11;
	localparam int TRAIN_BIT      = 10;
	localparam int PAT_HI         = 9;
	localparam int PAT_LO         = 8;
	localparam int FRAME_BIT      = 6;
	localparam int CLKSRC_BIT     = 4;
	localparam logic [31:0] CTL_WMASK = 32'h803f_af50;

	// ************************************************************
	// codes and symbols
	// ************************************************************
	localparam logic [1:0] PAT_ONE    = 2'h0;
	localparam logic [1:0] PAT_TWO    = 2'h1;
	localparam logic [1:0] PAT_IDLE   = 2'h2;
	localparam logic [1:0] PAT_NORMAL = 2'h3;
	localparam logic [3:0] PAT2_LEN   = 4'ha;
	localparam logic [3:0] IDLE_REPS  = 4'h5;
	localparam logic [8:0] SYM_D10_2  = 9'h04a;
	localparam logic [8:0] SYM_D11_6  = 9'h0cb;
	localparam logic [8:0] SYM_K28_5  = 9'h1bc;
	localparam logic [8:0] SYM_BS     = 9'h1bc;
	localparam logic [8:0] SYM_VBID   = 9'h008;

	typedef struct packed {
		logic [2:0] lanes;
		logic       auto_train;
		logic       framing;
	} dlrc_lock_type;

	typedef struct packed {
		logic       rx_on;
		logic [2:0] depth;
	} dlrc_vb_type;

	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_P2   = 2'b01,
		ST_IDLE = 2'b10,
		ST_RUN  = 2'b11
	} dlrc_state_type;

endpackage : dlrc_pkg

/* File: rtl/dlrc_top.sv */
/*
 * control register bank and training symbol source of the link receiver.
 * assumes apb master, vertical blank pulse and strap level on sys_clk.
 */
// Decided for this implementation: the register addresses and register access over APB.
module dlrc_top (
	input  wire logic        sys_clk,         // 125 mhz clock
	input  wire logic        sys_rst,         // sync reset, high
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb enable
	input  wire logic        pwrite,          // apb direction
	input  wire logic [11:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error
	input  wire logic        vblank,          // vertical blank pulse
	input  wire logic        strap_reversed,  // host link reversal strap
	input  wire logic        other_flip,      // override from other receivers
	input  wire logic        other_pll,       // pll enable from other receivers
	input  wire logic        other_clksrc,    // clock source from other receivers
	input  wire logic        other_links_on,  // any other link enabled
	output logic             rx_enabled,      // receiver active
	output logic [2:0]       lanes_active,    // applied lane count code
	output logic [3:0]       lane_enables,    // per lane enable
	output logic [2:0]       depth_active,    // applied color depth code
	output logic             lane_flip,       // lane order reversed
	output logic             link_pll_run,    // link pll on
	output logic             composite_sync,  // composite sync chosen
	output logic             auto_train,      // applied auto training
	output logic             framing,         // applied enhanced framing
	output logic             clk_fast,        // fast display clock chosen
	output logic [8:0]       tx_symbol,       // training symbol, msb is k
	output logic             no_video_flag,   // idle vb-id flag
	output logic             scramble_init    // scrambler/disparity init pulse
);

	// ************************************************************
	// bus decode
	// ************************************************************
	logic [31:0] ctl_r;
	logic [31:0] ctl_nxt;
	dlrc_pkg::dlrc_lock_type lock_r;
	dlrc_pkg::dlrc_vb_type   vb_r;
	logic        flip_r;
	logic        strap_r;
	dlrc_pkg::dlrc_state_type st_r;
	dlrc_pkg::dlrc_state_type st_nxt;
	logic [3:0]  idx_r;
	logic [3:0]  idx_nxt;
	logic [3:0]  reps_r;
	logic [3:0]  reps_nxt;
	logic [8:0]  sym_r;
	logic [8:0]  sym_nxt;
	logic        init_r;
	logic        init_nxt;
	logic        novid_r;

	wire access   = psel && penable;
	wire hit_ctl  = paddr == dlrc_pkg::CTL_OFF;
	wire hit_stat = paddr == dlrc_pkg::STAT_OFF;
	wire wr_ctl   = access && pwrite && hit_ctl;
	wire port_on  = vb_r.rx_on;
	wire links_off = !port_on && !other_links_on;
	wire [1:0] pat_sel = ctl_r[dlrc_pkg::PAT_HI:dlrc_pkg::PAT_LO];

	assign pready  = 1'b1;
	assign pslverr = access && !(hit_ctl || hit_stat);

	// ************************************************************
	// control register
	// ************************************************************
	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_ctl) begin
			ctl_nxt = pwdata & dlrc_pkg::CTL_WMASK;
			if (!links_off) begin
				ctl_nxt[dlrc_pkg::FLIP_BIT] = ctl_r[dlrc_pkg::FLIP_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctl_r <= dlrc_pkg::CTL_RESET;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// readback shows written copy; strap status is the strap level registered one cycle earlier
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_ctl) begin
			prdata = ctl_r;
			prdata[dlrc_pkg::STRAP_BIT] = strap_r;
		end else if (hit_stat) begin
			prdata = {25'h000_0000, st_r, lock_r.lanes, lock_r.auto_train, lock_r.framing};
		end
	end

	// ************************************************************
	// applied copies
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lock_r  <= '{lanes: 3'h0, auto_train: 1'b0, framing: 1'b1};
			vb_r    <= '{rx_on: 1'b0, depth: 3'h0};
			flip_r  <= 1'b0;
			strap_r <= 1'b0;
		end else begin
			strap_r <= strap_reversed;
			if (!port_on) begin
				lock_r.lanes      <= ctl_r[dlrc_pkg::LANE_HI:dlrc_pkg::LANE_LO];
				lock_r.auto_train <= ctl_r[dlrc_pkg::TRAIN_BIT];
				lock_r.framing    <= ctl_r[dlrc_pkg::FRAME_BIT];
			end
			if (links_off) begin
				flip_r <= ctl_r[dlrc_pkg::FLIP_BIT] || other_flip;
			end
			if (vblank) begin
				vb_r.rx_on <= ctl_r[dlrc_pkg::RX_ON_BIT];
				vb_r.depth <= ctl_r[dlrc_pkg::DEPTH_HI:dlrc_pkg::DEPTH_LO];
			end
		end
	end

	// ************************************************************
	// derived outputs
	// ************************************************************
	assign rx_enabled     = vb_r.rx_on;
	assign lanes_active   = lock_r.lanes;
	assign lane_enables   = !port_on ? 4'h0 :
		(lock_r.lanes == 3'h0) ? 4'h1 :
		(lock_r.lanes == 3'h1) ? 4'h3 :
		(lock_r.lanes == 3'h2) ? 4'h7 :
		(lock_r.lanes == 3'h3) ? 4'hf : 4'h0;
	assign depth_active   = vb_r.depth;
	assign lane_flip      = strap_r ^ flip_r;
	assign link_pll_run   = ctl_r[dlrc_pkg::PLL_BIT] || other_pll;
	assign composite_sync = ctl_r[dlrc_pkg::SYNC_BIT];
	assign auto_train     = lock_r.auto_train;
	assign framing        = lock_r.framing;
	assign clk_fast       = ctl_r[dlrc_pkg::CLKSRC_BIT] || other_clksrc;
	assign tx_symbol      = sym_r;
	assign no_video_flag  = novid_r;
	assign scramble_init  = init_r;

	// ************************************************************
	// training symbol sequencer
	// ************************************************************
	function automatic logic [8:0] p2_sym(input logic [3:0] i);
		case (i)
			4'h0, 4'h2: p2_sym = dlrc_pkg::SYM_K28_5;
			4'h1, 4'h3: p2_sym = dlrc_pkg::SYM_D11_6;
			default:    p2_sym = dlrc_pkg::SYM_D10_2;
		endcase
	endfunction : p2_sym

	wire p2_last = idx_r == dlrc_pkg::PAT2_LEN - 4'h1;

	always_comb begin
		st_nxt   = st_r;
		idx_nxt  = idx_r;
		reps_nxt = reps_r;
		sym_nxt  = dlrc_pkg::SYM_D10_2;
		init_nxt = 1'b0;
		case (st_r)
			dlrc_pkg::ST_OFF: begin
				idx_nxt = 4'h0;
				if (port_on && pat_sel == dlrc_pkg::PAT_TWO) begin
					st_nxt = dlrc_pkg::ST_P2;
				end else if (port_on && pat_sel == dlrc_pkg::PAT_IDLE) begin
					st_nxt   = dlrc_pkg::ST_IDLE;
					reps_nxt = 4'h0;
				end else if (port_on && pat_sel == dlrc_pkg::PAT_NORMAL) begin
					st_nxt = dlrc_pkg::ST_RUN;
				end
				sym_nxt = dlrc_pkg::SYM_D10_2;
			end
			dlrc_pkg::ST_P2: begin
				sym_nxt = p2_sym(idx_r);
				idx_nxt = p2_last ? 4'h0 : idx_r + 4'h1;
				if (p2_last && (pat_sel != dlrc_pkg::PAT_TWO || !port_on)) begin
					init_nxt = 1'b1;
					st_nxt   = dlrc_pkg::ST_OFF;
				end
			end
			dlrc_pkg::ST_IDLE: begin
				sym_nxt = idx_r[0] ? dlrc_pkg::SYM_VBID : dlrc_pkg::SYM_BS;
				idx_nxt = {3'h0, ~idx_r[0]};
				if (idx_r[0]) begin
					reps_nxt = reps_r + 4'h1;
				end
				if (idx_r[0] && reps_r == dlrc_pkg::IDLE_REPS - 4'h1) begin
					st_nxt = dlrc_pkg::ST_OFF;
				end
			end
			dlrc_pkg::ST_RUN: begin
				sym_nxt = 9'h000;
				if (!port_on || pat_sel != dlrc_pkg::PAT_NORMAL) begin
					st_nxt = dlrc_pkg::ST_OFF;
				end
			end
			default: st_nxt = dlrc_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r    <= dlrc_pkg::ST_OFF;
			idx_r   <= 4'h0;
			reps_r  <= 4'h0;
			sym_r   <= dlrc_pkg::SYM_D10_2;
			init_r  <= 1'b0;
			novid_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			idx_r   <= idx_nxt;
			reps_r  <= reps_nxt;
			sym_r   <= sym_nxt;
			init_r  <= init_nxt;
			novid_r <= st_r == dlrc_pkg::ST_IDLE && idx_r[0];
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_lanes_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && $past(port_on) |-> $stable(lock_r.lanes))
		else $error("lane count changed while port enabled");

	a_depth_vblank: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!$past(vblank) |-> $stable(vb_r.depth))
		else $error("color depth changed outside vertical blank");

	a_flip_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ctl && !links_off |=> $stable(ctl_r[dlrc_pkg::FLIP_BIT]))
		else $error("override written while link enabled");

	a_pll_or: assert property (@(posedge sys_clk) disable iff (sys_rst)
		other_pll |-> link_pll_run)
		else $error("pll not running on other enable");

	a_p2_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_P2 && idx_r == 4'h0 |=> sym_r == dlrc_pkg::SYM_K28_5 ##1
		sym_r == dlrc_pkg::SYM_D11_6)
		else $error("pattern 2 order wrong");

	a_init_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
		init_r |-> $past(st_r) == dlrc_pkg::ST_P2 && $past(p2_last))
		else $error("init pulse outside pattern 2 end");

	a_framing_rst: assert property (@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> ctl_r[dlrc_pkg::FRAME_BIT] && lock_r.framing)
		else $error("framing reset value wrong");

	a_clk_or: assert property (@(posedge sys_clk) disable iff (sys_rst)
		other_clksrc |-> clk_fast)
		else $error("clock source not ored");

	a_rx_vblank: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!$past(vblank) |-> $stable(rx_enabled))
		else $error("receiver enable changed outside vertical blank");

	// ************************************************************
	// register and lane checks
	// ************************************************************
	a_lanes_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && lock_r.lanes == 3'h0 |-> lane_enables == 4'h1)
		else $error("one lane code gives wrong enables");

	a_lanes_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && lock_r.lanes == 3'h1 |-> lane_enables == 4'h3)
		else $error("two lane code gives wrong enables");

	a_lanes_three: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && lock_r.lanes == 3'h2 |-> lane_enables == 4'h7)
		else $error("three lane code gives wrong enables");

	a_lanes_four: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && lock_r.lanes == 3'h3 |-> lane_enables == 4'hf)
		else $error("four lane code gives wrong enables");

	a_lanes_rsvd: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && lock_r.lanes[2] |-> lane_enables == 4'h0)
		else $error("reserved lane code enables lanes");

	a_lanes_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!port_on |-> lane_enables == 4'h0)
		else $error("lanes enabled while receiver off");

	a_train_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && $past(port_on) |-> $stable(lock_r.auto_train))
		else $error("auto training changed while port enabled");

	a_frame_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
		port_on && $past(port_on) |-> $stable(lock_r.framing))
		else $error("framing changed while port enabled");

	a_lock_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!port_on |=> lock_r.lanes == $past(ctl_r[dlrc_pkg::LANE_HI:dlrc_pkg::LANE_LO]))
		else $error("applied lane count not loaded while port off");

	a_ctl_pending: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ctl |=> ctl_r[dlrc_pkg::LANE_HI:dlrc_pkg::LANE_LO] == $past(pwdata[dlrc_pkg::LANE_HI:dlrc_pkg::LANE_LO]))
		else $error("written lane count not kept");

	a_strap_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		hit_ctl && !$past(sys_rst) |-> prdata[dlrc_pkg::STRAP_BIT] == $past(strap_reversed))
		else $error("strap status readback wrong");

	a_sync_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ctl |=> composite_sync == $past(pwdata[dlrc_pkg::SYNC_BIT]))
		else $error("sync select not taken from write");

	a_pll_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ctl && pwdata[dlrc_pkg::PLL_BIT] |=> link_pll_run)
		else $error("pll not running after enable write");

	a_clk_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ctl && pwdata[dlrc_pkg::CLKSRC_BIT] |=> clk_fast)
		else $error("fast clock not chosen after write");

	a_depth_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		vblank |=> depth_active == $past(ctl_r[dlrc_pkg::DEPTH_HI:dlrc_pkg::DEPTH_LO]))
		else $error("color depth not loaded at vertical blank");

	a_rx_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		vblank |=> rx_enabled == $past(ctl_r[dlrc_pkg::RX_ON_BIT]))
		else $error("receiver enable not loaded at vertical blank");

	a_flip_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		links_off |=> flip_r == ($past(ctl_r[dlrc_pkg::FLIP_BIT]) || $past(other_flip)))
		else $error("lane order override not ored");

	// ************************************************************
	// symbol sequencer checks
	// ************************************************************
	a_pat1_sym: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_OFF |=> tx_symbol == dlrc_pkg::SYM_D10_2)
		else $error("pattern 1 symbol wrong");

	a_p2_tail: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_P2 && idx_r > 4'h3 |=> tx_symbol == dlrc_pkg::SYM_D10_2)
		else $error("pattern 2 tail symbol wrong");

	a_p2_stay: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_P2 && !p2_last |=> st_r == dlrc_pkg::ST_P2)
		else $error("pattern 2 left before its end");

	a_p2_idx: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_P2 |-> idx_r < dlrc_pkg::PAT2_LEN)
		else $error("pattern 2 index out of range");

	a_init_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		init_r |=> !init_r)
		else $error("init pulse longer than one cycle");

	a_idle_bs: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_IDLE && !idx_r[0] |=> tx_symbol == dlrc_pkg::SYM_BS && !no_video_flag)
		else $error("idle blank start symbol wrong");

	a_idle_vbid: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_IDLE && idx_r[0] |=> tx_symbol == dlrc_pkg::SYM_VBID && no_video_flag)
		else $error("idle vb-id symbol or flag wrong");

	a_idle_reps: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_IDLE |-> reps_r < dlrc_pkg::IDLE_REPS)
		else $error("idle repeat count overran");

	a_run_sym: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == dlrc_pkg::ST_RUN |=> tx_symbol == 9'h000)
		else $error("normal data symbol wrong");

endmodule : dlrc_top

/* File: dv/dlrc_link_sink.sv */
/*
 * far-side model of the link: takes in the training symbol stream and
 * counts whole pattern 2 runs, idle vb-id symbols and malformed symbols.
 * assumes the symbol and flag change only on rising edges of sys_clk.
 */
module dlrc_link_sink (
	input  wire logic       sys_clk,  // clock
	input  wire logic       sys_rst,  // sync reset, high
	input  wire logic       p2_mode,  // pattern 2 selected by bench
	input  wire logic [8:0] sym,      // incoming symbol
	input  wire logic       nvf,      // no video flag
	output int              p2_done,  // whole pattern 2 runs
	output int              bad,      // malformed symbols
	output int              idle_cnt, // idle vb-id symbols
	output logic [3:0]      pos       // place within pattern 2
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] prev;

	function automatic logic [8:0] p2_sym(input logic [3:0] i);
		case (i)
			4'h0, 4'h2: return dlrc_pkg::SYM_K28_5;
			4'h1, 4'h3: return dlrc_pkg::SYM_D11_6;
			default: return dlrc_pkg::SYM_D10_2;
		endcase
	endfunction : p2_sym

	always @(posedge sys_clk) begin
		prev <= sym;
		if (sys_rst) begin
			pos <= 4'h0;
			p2_done <= 0;
			bad <= 0;
			idle_cnt <= 0;
		end else begin
			// once started, a run is followed to its tenth symbol
			if (pos != 4'h0 || (p2_mode && sym === dlrc_pkg::SYM_K28_5)) begin
				if (sym !== p2_sym(pos))
					bad <= bad + 1;
				pos <= (pos == 4'h9) ? 4'h0 : pos + 4'h1;
				if (pos == 4'h9)
					p2_done <= p2_done + 1;
			end
			if (nvf === 1'b1) begin
				idle_cnt <= idle_cnt + 1;
				if (sym !== dlrc_pkg::SYM_VBID || prev !== dlrc_pkg::SYM_BS)
					bad <= bad + 1;
			end
		end
	end
endmodule : dlrc_link_sink

/* File: dv/dlrc_top_test.sv */
/*
 * self-checking bench of the receiver control block: apb master, vblank
 * pulses, side inputs and the link sink model.
 * assumes zero-wait apb slave and one 125 mhz clock.
 */
module dlrc_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] RX   = 32'h8000_0000;
	localparam logic [31:0] BASE = 32'h0000_2040;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        vblank = 1'b0, strap_reversed = 1'b0, other_flip = 1'b0, other_pll = 1'b0;
	logic        other_clksrc = 1'b0, other_links_on = 1'b0, p2_mode = 1'b0, fl = 1'b0, fx = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, d, ex;
	logic        pready, pslverr, rx_enabled, lane_flip, link_pll_run, composite_sync;
	logic        auto_train, framing, clk_fast, no_video_flag, scramble_init;
	logic [2:0]  lanes_active, depth_active, pd;
	logic [3:0]  lane_enables, pos;
	logic [8:0]  tx_symbol;
	int          n_errors = 0, checked = 0, seed = 63, p2_done, bad, idle_cnt, i, k;

	always #4 sys_clk = ~sys_clk;

	dlrc_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vblank(vblank), .strap_reversed(strap_reversed),
		.other_flip(other_flip), .other_pll(other_pll), .other_clksrc(other_clksrc),
		.other_links_on(other_links_on), .rx_enabled(rx_enabled), .lanes_active(lanes_active),
		.lane_enables(lane_enables), .depth_active(depth_active), .lane_flip(lane_flip),
		.link_pll_run(link_pll_run), .composite_sync(composite_sync), .auto_train(auto_train),
		.framing(framing), .clk_fast(clk_fast), .tx_symbol(tx_symbol),
		.no_video_flag(no_video_flag), .scramble_init(scramble_init));

	dlrc_link_sink sink (.sys_clk(sys_clk), .sys_rst(sys_rst), .p2_mode(p2_mode), .sym(tx_symbol),
		.nvf(no_video_flag), .p2_done(p2_done), .bad(bad), .idle_cnt(idle_cnt), .pos(pos));

	function automatic logic [3:0] exp_lanes(input int c);
		return (c < 4) ? 4'((1 << (c + 1)) - 1) : 4'h0;
	endfunction : exp_lanes

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// one transfer, then one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			t++;
			if (t > 20) begin
				chk("pready", 0, 1);
				close_out();
			end
			@(posedge sys_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic vb;
		vblank <= 1'b1;
		@(posedge sys_clk);
		vblank <= 1'b0;
		@(posedge sys_clk);
	endtask : vb

	task automatic wait_rx(input logic v);
		k = 0;
		while (rx_enabled !== v && k < 20) begin
			k++;
			@(posedge sys_clk);
		end
		chk("rx_enabled", rx_enabled, v);
		if (k >= 20)
			close_out();
	endtask : wait_rx

	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, dlrc_pkg::CTL_OFF, 32'h0);
		chk("ctl_reset", rd, dlrc_pkg::CTL_RESET);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped_rd", {err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, 12'h008, 32'hffff_ffff);
		chk("unmapped_wr", err, 1'b1);
		for (i = 0; i < 12; i++) begin
			d = $random(seed);
			d[31] = 1'b0;
			strap_reversed <= d[0];
			other_flip <= d[1];
			other_pll <= d[2];
			other_clksrc <= d[3];
			other_links_on <= d[5];
			apb(1'b1, dlrc_pkg::CTL_OFF, d);
			if (!d[5]) begin
				fl = d[15];
				fx = d[15] | d[1];
			end
			ex = d & dlrc_pkg::CTL_WMASK;
			ex[15] = fl;
			ex[14] = d[0];
			apb(1'b0, dlrc_pkg::CTL_OFF, 32'h0);
			chk("ctl_rd", rd, ex);
			chk("lane_flip", lane_flip, d[0] ^ fx);
			chk("pll", link_pll_run, d[13] | d[2]);
			chk("clk_fast", clk_fast, d[4] | d[3]);
			chk("sync", composite_sync, d[11]);
			chk("lock_copy", {lanes_active, auto_train, framing}, {d[21:19], d[10], d[6]});
		end
		{strap_reversed, other_flip, other_pll, other_clksrc, other_links_on} <= 5'h0;
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE);
		vb();
		pd = 3'h0;
		// up to four lanes: fifth code taken as disabled
		for (i = 0; i < 5; i++) begin
			d = BASE | (i << 19) | (i << 16);
			apb(1'b1, dlrc_pkg::CTL_OFF, d | RX);
			chk("depth_hold", depth_active, pd);
			vb();
			wait_rx(1'b1);
			pd = 3'(i);
			chk("depth", depth_active, pd);
			chk("lanes", lane_enables, exp_lanes(i));
			repeat (4) @(posedge sys_clk);
			chk("pattern1", tx_symbol, dlrc_pkg::SYM_D10_2);
			apb(1'b1, dlrc_pkg::CTL_OFF, d);
			vb();
			wait_rx(1'b0);
		end
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE | RX | (3 << 19) | 32'h0000_0800);
		vb();
		wait_rx(1'b1);
		chk("sync_composite", composite_sync, 1'b1);
		apb(1'b1, dlrc_pkg::CTL_OFF, RX | 32'h0000_a400 | (1 << 19));
		apb(1'b0, dlrc_pkg::CTL_OFF, 32'h0);
		chk("pending", rd, RX | 32'h0000_2400 | (1 << 19));
		chk("held", {lanes_active, auto_train, framing}, 5'h0d);
		chk("flip_held", lane_flip, 1'b0);
		apb(1'b1, dlrc_pkg::CTL_OFF, 32'h0000_2400 | (1 << 19));
		vb();
		wait_rx(1'b0);
		@(posedge sys_clk);
		chk("applied", {lanes_active, auto_train, framing}, 5'h06);
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE | RX);
		vb();
		wait_rx(1'b1);
		p2_mode <= 1'b1;
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE | RX | 32'h100);
		repeat (13) @(posedge sys_clk);
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE | RX | 32'h300);
		k = 0;
		while (scramble_init !== 1'b1 && k < 40) begin
			k++;
			@(posedge sys_clk);
		end
		chk("scr_init", scramble_init, 1'b1);
		if (k >= 40)
			close_out();
		@(posedge sys_clk);
		p2_mode <= 1'b0;
		chk("p2_end", pos, 4'h0);
		chk("p2_runs", p2_done > 0, 1'b1);
		repeat (15) @(posedge sys_clk);
		chk("normal", {no_video_flag, tx_symbol}, 10'h0);
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE | RX | 32'h200);
		repeat (30) @(posedge sys_clk);
		apb(1'b1, dlrc_pkg::CTL_OFF, BASE | RX | 32'h300);
		repeat (15) @(posedge sys_clk);
		chk("idle_cnt", idle_cnt >= 5, 1'b1);
		chk("sym_bad", bad, 0);
		close_out();
	end
endmodule : dlrc_top_test
